// ### logic/power_status_cfg.svh
// Register offsets, reset values and timing counts for the power block
`ifndef POWER_STATUS_CFG_SVH
`define POWER_STATUS_CFG_SVH
`define OFS_INPUT_ENABLE 8'h73
`define OFS_POWER_CONFIG 8'h75
`define OFS_CHANNEL_STATUS 8'h76
`define OFS_MODE_STATUS 8'h77
`define OFS_CHECKSUM 8'h7e
`define RST_INPUT_ENABLE 8'hf0
`define RST_POWER_CONFIG 8'h00
`define RST_CHANNEL_STATUS 8'h00
`define RST_MODE_STATUS 8'h80
`define RST_CHECKSUM 8'h00
`define BIT_BIAS_ON 7
`define BIT_CONV_ON 6
`define BIT_LOOP_ON 5
`define BIT_DYN_ALLOW 4
`define FLD_GROUP_HI 3
`define FLD_GROUP_LO 2
`define FLD_MODE_HI 7
`define FLD_MODE_LO 5
`define MODE_SLEEP 3'h4
`define MODE_IDLE 3'h6
`define MODE_ACTIVE 3'h7
`define RAMP_TIME_NS 100
`define CLK_PERIOD_NS 5
`define RAMP_CYCLES ((`RAMP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ### logic/power_status_pkg.sv
// Types shared by the power configuration and status block
package power_status_pkg;
    typedef enum logic [1:0] {
        GROUP_TWO,
        GROUP_FOUR,
        GROUP_SIX,
        GROUP_EIGHT
    } group_sel_t;
    typedef enum {
        CH_OFF,
        CH_RISING,
        CH_ON,
        CH_FALLING
    } ch_state_t;
endpackage

// ### logic/channel_power_slot.sv
// One channel power sequencer with a settling delay
`timescale 1ns/1ps
`include "power_status_cfg.svh"
module channel_power_slot
    import power_status_pkg::*;
#(
    parameter int RAMP = `RAMP_CYCLES
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic want_on,
    output logic powered
);
    ch_state_t state_reg;
    logic [15:0] count_reg;
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_reg <= CH_OFF;
            count_reg <= 16'h0000;
        end else begin
            case (state_reg)
                CH_OFF: begin
                    if (want_on) begin
                        state_reg <= CH_RISING;
                        count_reg <= 16'(RAMP);
                    end
                end
                CH_RISING: begin
                    if (!want_on) begin
                        state_reg <= CH_OFF;
                    end else if (count_reg <= 16'h0001) begin
                        state_reg <= CH_ON;
                    end else begin
                        count_reg <= count_reg - 16'h0001;
                    end
                end
                CH_ON: begin
                    if (!want_on) begin
                        state_reg <= CH_FALLING;
                        count_reg <= 16'(RAMP);
                    end
                end
                CH_FALLING: begin
                    if (want_on) begin
                        state_reg <= CH_ON;
                    end else if (count_reg <= 16'h0001) begin
                        state_reg <= CH_OFF;
                    end else begin
                        count_reg <= count_reg - 16'h0001;
                    end
                end
                default: state_reg <= CH_OFF;
            endcase
        end
    end
    // Status reports settled power only, never the request
    assign powered = (state_reg == CH_ON) || (state_reg == CH_FALLING);
endmodule

// ### logic/power_config_and_status.sv
// Power configuration, channel status, mode status and checksum registers
// Operation
// - Config bit 7 powers the microphone bias up or down.
// - Converter power bit clear powers every channel down.
// - Converter power bit set powers only enabled channels up.
// - Config bit 5 powers the loop synthesiser up or down.
// - Dynamic bit clear: no per-channel changes while recording.
// - Dynamic bit set: channels change alone while others record.
// - Bits 3-2 pick dynamic group: channels 1-2, 1-4, 1-6, 1-8.
// - Status bit 7 is channel 1 down to bit 0 channel 8.
// - Status bits 3-0 reflect pulse-density channels only.
// - Mode field reads 4 in sleep or shutdown.
// - Mode field reads 6 when active with all channels off.
// - Mode field reads 7 when active with any channel on.
// - Mode register read-only, resets 80h, low five bits zero.
// - Readable checksum of control transactions, resets to zero.
// - Checksum write loads value; other writes update it.
// - Each of eight channels has its own input enable bit.
`timescale 1ns/1ps
`include "power_status_cfg.svh"
module power_config_and_status
    import power_status_pkg::*;
#(
    parameter int CHANNELS = 8,
    parameter int RAMP = `RAMP_CYCLES
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    input wire logic active,
    output logic bias_supply_power_on,
    output logic loop_synth_power_on,
    output logic [CHANNELS-1:0] channel_power_request
);
    logic [7:0] power_config_reg;
    logic [7:0] input_enable_reg;
    logic [7:0] control_checksum_reg;
    logic [7:0] rdata_reg;
    logic [CHANNELS-1:0] want_reg;
    logic [CHANNELS-1:0] want_next;
    logic [CHANNELS-1:0] settled;
    logic [7:0] channel_power_state;
    logic [7:0] group_mask;
    logic [2:0] device_mode_state;
    logic converter_power_on;
    logic dynamic_channel_power_allow;
    logic recording;
    group_sel_t dynamic_channel_group_select;
    logic [7:0] mode_status;

    assign converter_power_on = power_config_reg[`BIT_CONV_ON];
    assign dynamic_channel_power_allow = power_config_reg[`BIT_DYN_ALLOW];
    assign dynamic_channel_group_select = group_sel_t'(
        power_config_reg[`FLD_GROUP_HI:`FLD_GROUP_LO]);

    // Host writes; bits 1-0 are reserved but kept as stored
    always_ff @(posedge mclk) begin
        if (srst) begin
            power_config_reg <= `RST_POWER_CONFIG;
            input_enable_reg <= `RST_INPUT_ENABLE;
        end else if (wr_en) begin
            if (addr == `OFS_POWER_CONFIG)
                power_config_reg <= wdata;
            if (addr == `OFS_INPUT_ENABLE)
                input_enable_reg <= wdata;
        end
    end

    assign bias_supply_power_on = power_config_reg[`BIT_BIAS_ON];
    assign loop_synth_power_on = power_config_reg[`BIT_LOOP_ON];

    // Channels in the dynamic group, channel 1 at bit 7
    always_comb begin
        case (dynamic_channel_group_select)
            GROUP_TWO: group_mask = 8'hc0;
            GROUP_FOUR: group_mask = 8'hf0;
            GROUP_SIX: group_mask = 8'hfc;
            GROUP_EIGHT: group_mask = 8'hff;
            default: group_mask = 8'hff;
        endcase
    end

    assign recording = |settled;

    // Per-channel request. Without dynamic mode a running recording
    // freezes the channel set until the converter bit drops.
    always_comb begin
        want_next = want_reg;
        for (int i = 0; i < CHANNELS; i++) begin
            if (!converter_power_on) begin
                want_next[i] = 1'b0;
            end else if (!recording) begin
                want_next[i] = input_enable_reg[7-i];
            end else if (dynamic_channel_power_allow
                         && group_mask[7-i]) begin
                want_next[i] = input_enable_reg[7-i];
            end else begin
                want_next[i] = want_reg[i];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst)
            want_reg <= '0;
        else
            want_reg <= want_next;
    end

    assign channel_power_request = want_reg;

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : gen_slot
            // Channels 5-8 are pulse-density only; same sequencer
            channel_power_slot #(.RAMP(RAMP)) u_slot (
                .mclk(mclk),
                .srst(srst),
                .want_on(want_reg[g]),
                .powered(settled[g])
            );
        end
    endgenerate

    // Channel 1 on bit 7 down to channel 8 on bit 0
    always_comb begin
        channel_power_state = 8'h00;
        for (int i = 0; i < CHANNELS; i++)
            channel_power_state[7-i] = settled[i];
    end

    // Mode from settled channel state
    always_comb begin
        if (!active)
            device_mode_state = `MODE_SLEEP;
        else if (channel_power_state == 8'h00)
            device_mode_state = `MODE_IDLE;
        else
            device_mode_state = `MODE_ACTIVE;
    end

    // Reserved low bits read zero
    always_comb begin
        mode_status = 8'h00;
        mode_status[`FLD_MODE_HI:`FLD_MODE_LO] = device_mode_state;
    end

    // Write loads value; other writes fold address and data
    always_ff @(posedge mclk) begin
        if (srst)
            control_checksum_reg <= `RST_CHECKSUM;
        else if (wr_en && addr == `OFS_CHECKSUM)
            control_checksum_reg <= wdata;
        else if (wr_en)
            control_checksum_reg <= control_checksum_reg + addr + wdata;
    end

    // Read data registered; unmapped reads return zero
    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata_reg <= 8'h00;
        end else if (rd_en) begin
            case (addr)
                `OFS_INPUT_ENABLE: rdata_reg <= input_enable_reg;
                `OFS_POWER_CONFIG: rdata_reg <= power_config_reg;
                `OFS_CHANNEL_STATUS: rdata_reg <= channel_power_state;
                `OFS_MODE_STATUS: rdata_reg <= mode_status;
                `OFS_CHECKSUM: rdata_reg <= control_checksum_reg;
                default: rdata_reg <= 8'h00;
            endcase
        end
    end
    assign rdata = rdata_reg;

    // Cycles a channel-one request has waited for settled power, so the
    // ramp length is checked without a long repetition in a property
    logic [15:0] ramp_seen_reg;
    always_ff @(posedge mclk) begin
        if (srst || !want_reg[0])
            ramp_seen_reg <= 16'h0000;
        else if (!settled[0])
            ramp_seen_reg <= ramp_seen_reg + 16'h0001;
    end

    sequence s_conv_drop;
        $fell(converter_power_on);
    endsequence
    sequence s_all_off;
        want_reg == '0;
    endsequence
    sequence s_cfg_write;
        wr_en && addr == `OFS_POWER_CONFIG;
    endsequence
    sequence s_cksum_write;
        wr_en && addr == `OFS_CHECKSUM;
    endsequence
    sequence s_other_write;
        wr_en && addr != `OFS_CHECKSUM;
    endsequence
    sequence s_status_read;
        rd_en && addr == `OFS_CHANNEL_STATUS;
    endsequence
    sequence s_mode_read;
        rd_en && addr == `OFS_MODE_STATUS;
    endsequence

    a_conv_off_all: assert property (
        @(posedge mclk) disable iff (srst)
        s_conv_drop |=> s_all_off)
        else $error("Channels requested after converter power off");
    a_conv_on_enabled: assert property (
        @(posedge mclk) disable iff (srst)
        converter_power_on && !recording |=>
        want_reg[0] == $past(input_enable_reg[7]))
        else $error("Channel one request not following enable");
    a_conv_on_pdm: assert property (
        @(posedge mclk) disable iff (srst)
        converter_power_on && !recording |=>
        want_reg[7] == $past(input_enable_reg[0]))
        else $error("Channel eight request not following enable");
    a_bias_follow: assert property (
        @(posedge mclk) disable iff (srst)
        s_cfg_write |=>
        bias_supply_power_on == $past(wdata[7]))
        else $error("Bias power not following config write");
    a_loop_follow: assert property (
        @(posedge mclk) disable iff (srst)
        s_cfg_write |=>
        loop_synth_power_on == $past(wdata[5]))
        else $error("Loop power not following config write");
    a_static_hold: assert property (
        @(posedge mclk) disable iff (srst)
        recording && converter_power_on && !dynamic_channel_power_allow
        |=> $stable(want_reg))
        else $error("Channel set changed while recording");
    a_dyn_follow: assert property (
        @(posedge mclk) disable iff (srst)
        recording && converter_power_on && dynamic_channel_power_allow
        |=> want_reg[1:0] == {$past(input_enable_reg[6]),
            $past(input_enable_reg[7])})
        else $error("Dynamic channel request not following enable");
    a_group_limit: assert property (
        @(posedge mclk) disable iff (srst)
        recording && converter_power_on
        && dynamic_channel_group_select == GROUP_TWO
        |=> $stable(want_reg[7:2]))
        else $error("Channel outside dynamic group changed");
    a_group_four: assert property (
        @(posedge mclk) disable iff (srst)
        recording && converter_power_on
        && dynamic_channel_group_select == GROUP_FOUR
        |=> $stable(want_reg[7:4]))
        else $error("Channel outside group of four changed");
    a_group_six: assert property (
        @(posedge mclk) disable iff (srst)
        recording && converter_power_on
        && dynamic_channel_group_select == GROUP_SIX
        |=> $stable(want_reg[7:6]))
        else $error("Channel outside group of six changed");
    a_status_order: assert property (
        @(posedge mclk) disable iff (srst)
        s_status_read |=>
        rdata[7] == $past(settled[0]) && rdata[4] == $past(settled[3]))
        else $error("Channel status bit order wrong");
    a_pdm_status: assert property (
        @(posedge mclk) disable iff (srst)
        s_status_read |=>
        rdata[3:0] == {$past(settled[4]), $past(settled[5]),
            $past(settled[6]), $past(settled[7])})
        else $error("Pulse-density status bits wrong");
    a_mode_sleep: assert property (
        @(posedge mclk) disable iff (srst)
        !active |-> mode_status == 8'h80)
        else $error("Mode not sleep while inactive");
    a_mode_idle: assert property (
        @(posedge mclk) disable iff (srst)
        active && !recording |-> mode_status == 8'hc0)
        else $error("Idle mode field wrong");
    a_mode_active: assert property (
        @(posedge mclk) disable iff (srst)
        active |-> mode_status[7:5] == (recording ? 3'h7 : 3'h6))
        else $error("Active mode field wrong");
    a_mode_read: assert property (
        @(posedge mclk) disable iff (srst)
        s_mode_read |=>
        rdata == $past(mode_status) && rdata[4:0] == 5'h00)
        else $error("Mode register read wrong");
    a_reset_clear: assert property (
        @(posedge mclk) disable iff (srst)
        $fell(srst) |-> control_checksum_reg == `RST_CHECKSUM
        && channel_power_state == `RST_CHANNEL_STATUS)
        else $error("Checksum or status not cleared by reset");
    a_cksum_load: assert property (
        @(posedge mclk) disable iff (srst)
        s_cksum_write |=>
        control_checksum_reg == $past(wdata))
        else $error("Checksum write not loaded");
    a_cksum_fold: assert property (
        @(posedge mclk) disable iff (srst)
        s_other_write |=> control_checksum_reg ==
        8'($past(control_checksum_reg) + $past(addr) + $past(wdata)))
        else $error("Checksum not updated by register write");
    a_status_late: assert property (
        @(posedge mclk) disable iff (srst)
        $rose(want_reg[0]) && !settled[0] |=> !settled[0])
        else $error("Status rose before power transition");
    a_status_ramp: assert property (
        @(posedge mclk) disable iff (srst)
        $rose(settled[0]) |-> ramp_seen_reg == 16'(RAMP + 1))
        else $error("Channel one status rose before the ramp ended");
endmodule

// ### verif/host_model.sv
// Host processor model driving the control port of the power block
`timescale 1ns/1ps
module host_model (
    input wire logic mclk,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic active,
    input wire logic [7:0] rdata
);
    logic [7:0] ck;

    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        active = 1'b0;
        ck = 8'h00;
    end

    // Every write except to 7e folds into the expected running sum; a 7e write loads it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        ck = (a == 8'h7e) ? d : 8'(ck + a + d);
        @(posedge mclk);
        #1;
        wr_en = 1'b0;
        addr = ~a; // Released lines must not keep the last value
        wdata = ~d;
    endtask

    // Waits one edge more than needed, since rdata stands until next read
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        #1;
        rd_en = 1'b1;
        addr = a;
        @(posedge mclk);
        #1;
        rd_en = 1'b0;
        addr = ~a;
        @(posedge mclk);
        #1;
        d = rdata;
    endtask
endmodule

// ### verif/testbench.sv
// Self-checking bench for the power configuration and status block
`timescale 1ns/1ps
module testbench;
    localparam int RAMP = 2;
    logic mclk;
    logic srst;
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic active;
    logic bias_supply_power_on;
    logic loop_synth_power_on;
    logic [7:0] channel_power_request;
    logic [7:0] rv;
    logic [7:0] req;
    logic [7:0] msk;
    int err_count;
    int checks_done;

    initial mclk = 1'b0;
    always #2.5 mclk = ~mclk;

    host_model host (.mclk(mclk), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wdata(wdata), .active(active), .rdata(rdata));

    power_config_and_status #(.CHANNELS(8), .RAMP(RAMP)) DUT (
        .mclk(mclk),
        .srst(srst),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .addr(addr),
        .wdata(wdata),
        .rdata(rdata),
        .active(active),
        .bias_supply_power_on(bias_supply_power_on),
        .loop_synth_power_on(loop_synth_power_on),
        .channel_power_request(channel_power_request)
    );

    task automatic chk(input string n, input logic [7:0] s,
                       input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rv);
        chk($sformatf("reg %h", a), rv, e);
    endtask

    // Settle time is fixed by the ramp parameter plus margin
    task automatic wt();
        repeat (RAMP + 4) @(posedge mclk);
        #1;
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        final_report();
    end

    initial begin
        err_count = 0;
        checks_done = 0;
        srst = 1'b1;
        repeat (12) @(posedge mclk);
        #1;
        srst = 1'b0;
        rchk(8'h76, 8'h00);
        rchk(8'h77, 8'h80);
        rchk(8'h7e, 8'h00);
        rchk(8'h73, 8'hf0);
        rchk(8'h10, 8'h00);
        $display("test reset done");
        host.wr(8'h75, 8'ha0);
        wt();
        chk("bias", {7'h00, bias_supply_power_on}, 8'h01);
        chk("loop", {7'h00, loop_synth_power_on}, 8'h01);
        chk("request", channel_power_request, 8'h00);
        host.active = 1'b1;
        rchk(8'h77, 8'hc0);
        host.wr(8'h75, 8'he0);
        wt();
        chk("request", channel_power_request, 8'h0f);
        rchk(8'h76, 8'hf0);
        rchk(8'h77, 8'he0);
        $display("test power up done");
        host.wr(8'h73, 8'h08);
        wt();
        chk("held", channel_power_request, 8'h0f);
        host.wr(8'h75, 8'h20);
        wt();
        chk("bias", {7'h00, bias_supply_power_on}, 8'h00);
        chk("request", channel_power_request, 8'h00);
        host.wr(8'h75, 8'he0);
        wt();
        rchk(8'h76, 8'h08);
        $display("test held enables done");
        req = 8'h10;
        for (int g = 0; g < 4; g++) begin
            msk = 8'((4 << (2 * g)) - 1);
            host.wr(8'h75, 8'hf0 | 8'(g << 2));
            host.wr(8'h73, 8'hff);
            wt();
            req = req | msk;
            chk("group up", channel_power_request, req);
            host.wr(8'h73, 8'h80); // Channel one stays on
            wt();
            req = (req & ~msk) | 8'h01;
            chk("group down", channel_power_request, req);
        end
        rchk(8'h76, 8'h80);
        $display("test dynamic groups done");
        host.wr(8'h77, 8'h00);
        rchk(8'h77, 8'he0);
        rchk(8'h7e, host.ck);
        host.wr(8'h7e, 8'h5a);
        rchk(8'h7e, 8'h5a);
        host.active = 1'b0;
        rchk(8'h77, 8'h80);
        $display("test checksum and mode done");
        srst = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        srst = 1'b0;
        host.ck = 8'h00;
        chk("request", channel_power_request, 8'h00);
        chk("bias", {7'h00, bias_supply_power_on}, 8'h00);
        rchk(8'h76, 8'h00);
        rchk(8'h77, 8'h80);
        rchk(8'h7e, host.ck);
        $display("test mid-run reset done");
        final_report();
    end
endmodule
